// ==== shared/lpms_pkg.sv ====
/*
  lpms_pkg: shared constants for the low power mode sequencer.
  Assumes a single sys_clk domain at 20 MHz and a plain register port.
*/
`default_nettype none
package lpms_pkg;

  // sequencer states
  typedef enum logic [2:0] {
    LPMS_OFF    = 3'b000,
    LPMS_DEEP   = 3'b001,
    LPMS_SLEEP  = 3'b010,
    LPMS_WAKEUP = 3'b011,
    LPMS_ON     = 3'b100
  } lpms_state_e;

  // operating mode reported to software, three modes only
  localparam logic [1:0] MODE_ACTIVE = 2'h0;
  localparam logic [1:0] MODE_SLEEP  = 2'h1;
  localparam logic [1:0] MODE_DEEP   = 2'h2;

  // register offsets
  localparam logic [3:0] REG_CTRL    = 4'h0;
  localparam logic [3:0] REG_CLKEN   = 4'h1;
  localparam logic [3:0] REG_STATUS  = 4'h2;
  localparam logic [3:0] REG_IRQ_ST  = 4'h3;
  localparam logic [3:0] REG_IRQ_CLR = 4'h4;
  localparam logic [3:0] REG_IRQ_EN  = 4'h5;
  localparam logic [3:0] REG_RETAIN  = 4'h6;

  // control fields
  localparam int CTRL_SLEEP_REQ = 0;
  localparam int CTRL_DEEP_REQ  = 1;
  localparam int CTRL_PAD_HOLD  = 2;

  // interrupt status fields
  localparam int IRQ_WAKE = 0;
  localparam int IRQ_ON   = 1;
  localparam int IRQ_DEEP = 2;

  // widths and reset values
  localparam int          NUM_BLK     = 8;
  localparam int          NUM_WAKE    = 4;
  localparam int          NUM_PAD     = 17;
  localparam logic [7:0]  CLKEN_RST   = 8'hff;
  localparam logic [2:0]  CTRL_RST    = 3'h0;
  localparam logic [2:0]  IRQ_EN_RST  = 3'h0;

  // synchroniser depth for pins
  localparam int SYNC_DEPTH = 3;

  // wakeup settle timeout: time in ns and derived cycles
  localparam int CLK_PERIOD_NS   = 50;
  localparam int WAKE_TMO_NS     = 100000;
  localparam int WAKE_TMO_CYC    = WAKE_TMO_NS / CLK_PERIOD_NS;

endpackage : lpms_pkg
`default_nettype wire

// ==== rtl/lpms_pin_sync.sv ====
/*
  lpms_pin_sync: three-stage pin synchroniser with agreement filter.
  Assumes the pin is asynchronous to sys_clk.
*/
`timescale 1ns/1ps
`default_nettype none
module lpms_pin_sync #(
  parameter logic RST_VAL = 1'b0
) (
  input  wire logic sys_clk,
  input  wire logic rst_n,
  input  wire logic pin_in,
  output var  logic level_out
);

  logic [2:0] sync_ff;
  logic       level_ff;
  logic       nxt_level;

  // stage 1 feeds only stage 2
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      sync_ff <= {3{RST_VAL}};
    end else begin
      sync_ff <= {sync_ff[1:0], pin_in};
    end
  end

  // accept a change once stages two and three agree
  assign nxt_level = (sync_ff[1] == sync_ff[2]) ? sync_ff[2] : level_ff;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      level_ff <= RST_VAL;
    end else begin
      level_ff <= nxt_level;
    end
  end

  assign level_out = level_ff;

endmodule : lpms_pin_sync
`default_nettype wire

// ==== rtl/lpms_sequencer.sv ====
/*
  lpms_sequencer: power mode sequencer (off, deep-sleep, sleep, wakeup, on),
  clock enables, cpu wait gating, pad hold and a small register file.
  Assumes a 20 MHz sys_clk, synchronous rst_n, and a plain register port.
*/
// The address-and-strobe port and the placing of the registers are this design's own decisions.
// Operation
// - chip enable low: off, rtc off, cleared
// - deep-sleep keeps only rtc domain and retention
// - sleep: rtc runs, crystal enable low
// - any wake source enters wakeup from sleep
// - wakeup enables crystal and plls, then on
// - on: fast clock gated by per-block enables
// - wait instruction gates cpu clock alone
// - exactly three modes: active, sleep, deep
// - pad output enables held low when down and pad hold is set
// - external reset input is active low
`timescale 1ns/1ps
`default_nettype none
module lpms_sequencer (
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic        chip_power_up_pin,
  input  wire logic        external_reset_n,
  input  wire logic        wake_mac,
  input  wire logic        wake_host,
  input  wire logic        wake_rtc_timer,
  input  wire logic        wake_ext_irq,
  input  wire logic        xtal_stable,
  input  wire logic        pll_locked,
  input  wire logic        wait_for_interrupt_instr,
  input  wire logic        cpu_irq_pending,
  input  wire logic [16:0] pad_oe_in,
  input  wire logic [3:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output var  logic [31:0] reg_rdata,
  output var  logic        rtc_power_en,
  output var  logic        core_power_en,
  output var  logic        xtal_en,
  output var  logic        pll_en,
  output var  logic        hs_clk_run,
  output var  logic [7:0]  blk_clk_en,
  output var  logic        cpu_clk_en,
  output var  logic [16:0] pad_oe_out,
  output var  logic [1:0]  op_mode,
  output var  logic        deep_sleep_wake_output,
  output var  logic        irq
);

  lpms_pkg::lpms_state_e state_ff;
  lpms_pkg::lpms_state_e nxt_state;

  logic        chip_up;
  logic        ext_rst_lvl;
  logic        chip_rst;
  logic [2:0]  ctrl_ff;
  logic [7:0]  clken_ff;
  logic [2:0]  irq_st_ff;
  logic [2:0]  irq_en_ff;
  logic [31:0] retain_ff;
  logic        cpu_wait_ff;
  logic        nxt_cpu_wait;
  logic        released_ff;
  logic [31:0] reg_rdata_ff;
  logic [31:0] nxt_rdata;
  logic [3:0]  wake_vec;
  logic        any_wake;
  logic        osc_ok;
  logic [2:0]  irq_set;
  logic        wr_ctrl;
  logic        wr_clken;
  logic        wr_clr;
  logic        wr_en;
  logic        wr_retain;
  logic [2:0]  ctrl_clean;

  // pin synchronisers; chip enable and reset start low
  lpms_pin_sync #(.RST_VAL(1'b0)) u_sync_pu (
    .sys_clk   (sys_clk),
    .rst_n     (rst_n),
    .pin_in    (chip_power_up_pin),
    .level_out (chip_up)
  );

  lpms_pin_sync #(.RST_VAL(1'b0)) u_sync_rst (
    .sys_clk   (sys_clk),
    .rst_n     (rst_n),
    .pin_in    (external_reset_n),
    .level_out (ext_rst_lvl)
  );

  // chip-level clear: chip enable low or external reset low
  assign chip_rst = !chip_up || !ext_rst_lvl;

  // wake source synchronisers, one per source
  genvar gi;
  for (gi = 0; gi < lpms_pkg::NUM_WAKE; gi++) begin : g_wake
    lpms_pin_sync #(.RST_VAL(1'b0)) u_sync_wake (
      .sys_clk   (sys_clk),
      .rst_n     (rst_n),
      .pin_in    ((gi == 0) ? wake_mac : (gi == 1) ? wake_host :
                  (gi == 2) ? wake_rtc_timer : wake_ext_irq),
      .level_out (wake_vec[gi])
    );
  end

  assign any_wake = |wake_vec;
  assign osc_ok   = xtal_stable && pll_locked;

  // register write decode
  assign wr_ctrl   = reg_wr && (reg_addr == lpms_pkg::REG_CTRL);
  assign wr_clken  = reg_wr && (reg_addr == lpms_pkg::REG_CLKEN);
  assign wr_clr    = reg_wr && (reg_addr == lpms_pkg::REG_IRQ_CLR);
  assign wr_en     = reg_wr && (reg_addr == lpms_pkg::REG_IRQ_EN);
  assign wr_retain = reg_wr && (reg_addr == lpms_pkg::REG_RETAIN);

  // sleep requests are one-shot: cleared once the state is entered
  assign ctrl_clean = {ctrl_ff[lpms_pkg::CTRL_PAD_HOLD], 2'b00};

  // state transitions
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      lpms_pkg::LPMS_OFF: begin
        nxt_state = lpms_pkg::LPMS_WAKEUP;
      end
      lpms_pkg::LPMS_DEEP: begin
        nxt_state = lpms_pkg::LPMS_DEEP; // left only through rst_n or chip-level clear
      end
      lpms_pkg::LPMS_SLEEP: begin
        if (any_wake) begin
          nxt_state = lpms_pkg::LPMS_WAKEUP;
        end
      end
      lpms_pkg::LPMS_WAKEUP: begin
        if (osc_ok) begin
          nxt_state = lpms_pkg::LPMS_ON;
        end
      end
      lpms_pkg::LPMS_ON: begin
        if (ctrl_ff[lpms_pkg::CTRL_DEEP_REQ]) begin
          nxt_state = lpms_pkg::LPMS_DEEP;
        end else if (ctrl_ff[lpms_pkg::CTRL_SLEEP_REQ]) begin
          nxt_state = lpms_pkg::LPMS_SLEEP;
        end
      end
      default: begin
        nxt_state = lpms_pkg::LPMS_OFF;
      end
    endcase
  end

  // state register; chip-level clear forces off
  always_ff @(posedge sys_clk) begin
    if (!rst_n || chip_rst) begin
      state_ff <= lpms_pkg::LPMS_OFF;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // control and clock enable registers
  always_ff @(posedge sys_clk) begin
    if (!rst_n || chip_rst) begin
      ctrl_ff  <= lpms_pkg::CTRL_RST;
      clken_ff <= lpms_pkg::CLKEN_RST;
    end else begin
      if (wr_ctrl) begin
        ctrl_ff <= reg_wdata[2:0];
      end else if (state_ff != lpms_pkg::LPMS_ON) begin
        ctrl_ff <= ctrl_clean;
      end
      if (wr_clken) begin
        clken_ff <= reg_wdata[7:0];
      end
    end
  end

  // retention word survives deep-sleep and external reset, cleared only by rst_n or chip enable low
  always_ff @(posedge sys_clk) begin
    if (!rst_n || !chip_up) begin
      retain_ff <= 32'h0000_0000;
    end else if (wr_retain) begin
      retain_ff <= reg_wdata;
    end
  end

  // interrupt events: entered wakeup, entered on, entered deep-sleep
  assign irq_set[lpms_pkg::IRQ_WAKE] = (nxt_state == lpms_pkg::LPMS_WAKEUP) &&
                                       (state_ff != lpms_pkg::LPMS_WAKEUP);
  assign irq_set[lpms_pkg::IRQ_ON]   = (nxt_state == lpms_pkg::LPMS_ON) &&
                                       (state_ff != lpms_pkg::LPMS_ON);
  assign irq_set[lpms_pkg::IRQ_DEEP] = (nxt_state == lpms_pkg::LPMS_DEEP) &&
                                       (state_ff != lpms_pkg::LPMS_DEEP);

  // sticky status, set wins over clear
  always_ff @(posedge sys_clk) begin
    if (!rst_n || chip_rst) begin
      irq_st_ff <= 3'h0;
      irq_en_ff <= lpms_pkg::IRQ_EN_RST;
    end else begin
      irq_st_ff <= (irq_st_ff & ~(wr_clr ? reg_wdata[2:0] : 3'h0)) | irq_set;
      if (wr_en) begin
        irq_en_ff <= reg_wdata[2:0];
      end
    end
  end

  assign irq = |(irq_st_ff & irq_en_ff);

  // cpu wait gating: set by wait instruction, cleared by pending irq
  always_comb begin
    nxt_cpu_wait = cpu_wait_ff;
    if (state_ff != lpms_pkg::LPMS_ON) begin
      nxt_cpu_wait = 1'b0;
    end else if (cpu_irq_pending) begin
      nxt_cpu_wait = 1'b0;
    end else if (wait_for_interrupt_instr) begin
      nxt_cpu_wait = 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n || chip_rst) begin
      cpu_wait_ff <= 1'b0;
    end else begin
      cpu_wait_ff <= nxt_cpu_wait;
    end
  end

  // fast clock release after oscillator and pll stable in on state
  always_ff @(posedge sys_clk) begin
    if (!rst_n || chip_rst) begin
      released_ff <= 1'b0;
    end else begin
      released_ff <= (state_ff == lpms_pkg::LPMS_ON) && osc_ok;
    end
  end

  // power, oscillator and clock outputs per state
  assign rtc_power_en  = (state_ff != lpms_pkg::LPMS_OFF);
  assign core_power_en = (state_ff == lpms_pkg::LPMS_WAKEUP) ||
                         (state_ff == lpms_pkg::LPMS_ON);
  assign xtal_en       = core_power_en;
  assign pll_en        = core_power_en;
  assign hs_clk_run    = released_ff && (state_ff == lpms_pkg::LPMS_ON);
  assign blk_clk_en    = hs_clk_run ? clken_ff : 8'h00;
  assign cpu_clk_en    = hs_clk_run && clken_ff[0] && !cpu_wait_ff;

  // deep-sleep wakeup pulls the board reset low on a wake event
  assign deep_sleep_wake_output = !((state_ff == lpms_pkg::LPMS_DEEP) && any_wake);

  // pad output enables held low while powered down when hold is set
  assign pad_oe_out = (ctrl_ff[lpms_pkg::CTRL_PAD_HOLD] && !core_power_en) ?
                      17'h00000 : pad_oe_in;

  // mode reported to software: three modes only
  always_comb begin
    case (state_ff)
      lpms_pkg::LPMS_DEEP:  op_mode = lpms_pkg::MODE_DEEP;
      lpms_pkg::LPMS_SLEEP: op_mode = lpms_pkg::MODE_SLEEP;
      default:              op_mode = lpms_pkg::MODE_ACTIVE;
    endcase
  end

  // read data selection
  always_comb begin
    case (reg_addr)
      lpms_pkg::REG_CTRL:   nxt_rdata = {29'h0, ctrl_ff};
      lpms_pkg::REG_CLKEN:  nxt_rdata = {24'h0, clken_ff};
      lpms_pkg::REG_STATUS: nxt_rdata = {24'h0, osc_ok, cpu_wait_ff, op_mode, 1'b0, state_ff};
      lpms_pkg::REG_IRQ_ST: nxt_rdata = {29'h0, irq_st_ff};
      lpms_pkg::REG_IRQ_EN: nxt_rdata = {29'h0, irq_en_ff};
      lpms_pkg::REG_RETAIN: nxt_rdata = retain_ff;
      default:              nxt_rdata = 32'h0000_0000;
    endcase
  end

  // read data valid in the cycle after the read strobe only
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      reg_rdata_ff <= 32'h0000_0000;
    end else begin
      reg_rdata_ff <= reg_rd ? nxt_rdata : 32'h0000_0000;
    end
  end

  assign reg_rdata = reg_rdata_ff;

endmodule : lpms_sequencer
`default_nettype wire

// ==== bench/lpms_seq_checker.sv ====
/* lpms_seq_checker: port assertions for lpms_sequencer.
   Assumes one sys_clk domain with synchronous rst_n; bound below. */
`timescale 1ns/1ps
`default_nettype none
module lpms_seq_checker (
  input wire logic        sys_clk,
  input wire logic        rst_n,
  input wire logic        chip_power_up_pin,
  input wire logic        wake_mac,
  input wire logic        wake_host,
  input wire logic        wake_rtc_timer,
  input wire logic        wake_ext_irq,
  input wire logic        xtal_stable,
  input wire logic        pll_locked,
  input wire logic        wait_for_interrupt_instr,
  input wire logic        cpu_irq_pending,
  input wire logic [16:0] pad_oe_in,
  input wire logic [16:0] pad_oe_out,
  input wire logic        rtc_power_en,
  input wire logic        core_power_en,
  input wire logic        xtal_en,
  input wire logic        pll_en,
  input wire logic        hs_clk_run,
  input wire logic [7:0]  blk_clk_en,
  input wire logic        cpu_clk_en,
  input wire logic [1:0]  op_mode
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // any wake source
  wire logic any_wake = wake_mac | wake_host | wake_rtc_timer | wake_ext_irq;
  sequence s_pin_low; !chip_power_up_pin [*8]; endsequence
  sequence s_slp_wake; (op_mode == lpms_pkg::MODE_SLEEP) && any_wake ##1 any_wake [*4]; endsequence
  sequence s_wait_taken; hs_clk_run && wait_for_interrupt_instr && !cpu_irq_pending; endsequence
  property p_off; s_pin_low |-> !rtc_power_en && !core_power_en; endproperty
  property p_deep; op_mode == lpms_pkg::MODE_DEEP |-> !core_power_en && !xtal_en && !pll_en; endproperty
  property p_sleep; op_mode == lpms_pkg::MODE_SLEEP |-> !core_power_en && !xtal_en; endproperty
  property p_wake; s_slp_wake |-> ##[0:3] (core_power_en && xtal_en && pll_en); endproperty
  property p_blk; (blk_clk_en != 8'h00) |-> hs_clk_run && core_power_en && xtal_en; endproperty
  property p_rel; $rose(hs_clk_run) |-> $past(xtal_stable) && $past(pll_locked) && core_power_en; endproperty
  property p_wait; s_wait_taken |=> !cpu_clk_en; endproperty
  property p_irq; cpu_irq_pending ##1 blk_clk_en[0] |-> cpu_clk_en; endproperty
  property p_pad; pad_oe_out != pad_oe_in |-> pad_oe_out == 17'h0 && !core_power_en; endproperty
  a_off: assert property (p_off)
    else $error("rtc domain powered while chip disabled");
  a_deep: assert property (p_deep)
    else $error("core powered in deep sleep");
  a_sleep: assert property (p_sleep)
    else $error("crystal enabled in sleep");
  a_wake: assert property (p_wake)
    else $error("wake in sleep did not power up");
  a_blk: assert property (p_blk)
    else $error("block clock without fast clock");
  a_rel: assert property (p_rel)
    else $error("fast clock before oscillator stable");
  a_wait: assert property (p_wait)
    else $error("cpu clock not gated by wait");
  a_irq: assert property (p_irq)
    else $error("cpu clock not reopened by interrupt");
  a_pad: assert property (p_pad)
    else $error("pad enable altered while powered");
endmodule : lpms_seq_checker
bind lpms_sequencer lpms_seq_checker u_chk (
  .sys_clk                  (sys_clk),
  .rst_n                    (rst_n),
  .chip_power_up_pin        (chip_power_up_pin),
  .wake_mac                 (wake_mac),
  .wake_host                (wake_host),
  .wake_rtc_timer           (wake_rtc_timer),
  .wake_ext_irq             (wake_ext_irq),
  .xtal_stable              (xtal_stable),
  .pll_locked               (pll_locked),
  .wait_for_interrupt_instr (wait_for_interrupt_instr),
  .cpu_irq_pending          (cpu_irq_pending),
  .pad_oe_in                (pad_oe_in),
  .pad_oe_out               (pad_oe_out),
  .rtc_power_en             (rtc_power_en),
  .core_power_en            (core_power_en),
  .xtal_en                  (xtal_en),
  .pll_en                   (pll_en),
  .hs_clk_run               (hs_clk_run),
  .blk_clk_en               (blk_clk_en),
  .cpu_clk_en               (cpu_clk_en),
  .op_mode                  (op_mode)
);
`default_nettype wire

// ==== bench/lpms_board_model.sv ====
/* lpms_board_model: board enable, reset and wake sources.
   Assumes the oscillator and pll settle a few cycles after enable. */
`timescale 1ns/1ps
`default_nettype none
module lpms_board_model (
  input  wire logic       sys_clk,
  input  wire logic       pwr_on,
  input  wire logic       btn_n,
  input  wire logic       slow,
  input  wire logic [3:0] wake_req,
  input  wire logic       xtal_en,
  input  wire logic       pll_en,
  input  wire logic       deep_sleep_wake_output,
  output wire logic       chip_power_up_pin,
  output wire logic       external_reset_n,
  output wire logic       wake_mac,
  output wire logic       wake_host,
  output wire logic       wake_rtc_timer,
  output wire logic       wake_ext_irq,
  output wire logic       xtal_stable,
  output wire logic       pll_locked
);
  logic [3:0] cnt_ff = 4'h0;
  // settle counter, longer when slow
  always_ff @(posedge sys_clk) begin
    cnt_ff <= !xtal_en ? 4'h0 : (cnt_ff == 4'hf) ? cnt_ff : cnt_ff + 4'h1;
  end
  // pins and status
  assign xtal_stable       = xtal_en && cnt_ff >= (slow ? 4'hc : 4'h2);
  assign pll_locked        = pll_en && cnt_ff >= (slow ? 4'hd : 4'h3);
  assign chip_power_up_pin = pwr_on;
  assign external_reset_n  = btn_n & deep_sleep_wake_output;
  assign {wake_ext_irq, wake_rtc_timer, wake_host, wake_mac} = wake_req;
endmodule : lpms_board_model
`default_nettype wire

// ==== bench/tb_top.sv ====
/* tb_top: directed tests of lpms_sequencer with the board model.
   Assumes the checker binds itself to the sequencer. */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic        sys_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        pwr_on = 1'b1;
  logic        btn_n = 1'b1;
  logic        slow = 1'b0;
  logic        wait_for_interrupt_instr = 1'b0;
  logic        cpu_irq_pending = 1'b0;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [3:0]  wake_req = 4'h0;
  logic [3:0]  reg_addr = 4'h0;
  logic [16:0] pad_oe_in = 17'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic [31:0] rdv;
  wire logic chip_power_up_pin, external_reset_n, wake_mac, wake_host, wake_rtc_timer, wake_ext_irq;
  wire logic xtal_stable, pll_locked, rtc_power_en, core_power_en, xtal_en, pll_en, hs_clk_run;
  wire logic cpu_clk_en, deep_sleep_wake_output, irq;
  wire logic [31:0] reg_rdata;
  wire logic [7:0]  blk_clk_en;
  wire logic [16:0] pad_oe_out;
  wire logic [1:0]  op_mode;
  int error_cnt = 0;
  int compares = 0;
  // 20 MHz clock
  always #25 sys_clk = ~sys_clk;
  lpms_board_model u_board (.*);
  lpms_sequencer uut (.*);
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [3:0] a, output logic [31:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(negedge sys_clk);
    d = reg_rdata;
  endtask : rd_reg
  task automatic wait_on;
    int n = 0;
    while (hs_clk_run !== 1'b1 && n < 200) begin
      @(negedge sys_clk);
      n++;
    end
    chk("hs_clk_run", 32'h1, {31'h0, hs_clk_run});
  endtask : wait_on
  task automatic t_regs;
    rd_reg(lpms_pkg::REG_CLKEN, rdv);
    chk("clken", 32'hff, rdv);
    rd_reg(lpms_pkg::REG_STATUS, rdv);
    chk("status", {24'h0, 1'b1, 1'b0, lpms_pkg::MODE_ACTIVE, 1'b0, lpms_pkg::LPMS_ON}, rdv);
    wr_reg(4'hf, 32'h1);
    rd_reg(4'hf, rdv);
    chk("unmapped", 32'h0, rdv);
    rd_reg(lpms_pkg::REG_IRQ_CLR, rdv);
    chk("irq_clr", 32'h0, rdv);
    $display("t_regs done");
  endtask : t_regs
  task automatic t_clk;
    wr_reg(lpms_pkg::REG_CLKEN, 32'h0a);
    @(negedge sys_clk);
    chk("blk_clk_en", 32'h0a, {24'h0, blk_clk_en});
    chk("cpu_clk_en", 32'h0, {31'h0, cpu_clk_en});
    wr_reg(lpms_pkg::REG_CLKEN, 32'hff);
    $display("t_clk done");
  endtask : t_clk
  task automatic t_wait;
    @(posedge sys_clk);
    wait_for_interrupt_instr <= 1'b1;
    @(posedge sys_clk);
    wait_for_interrupt_instr <= 1'b0;
    @(negedge sys_clk);
    chk("cpu_clk_en", 32'h0, {31'h0, cpu_clk_en});
    chk("blk_clk_en", 32'hff, {24'h0, blk_clk_en});
    @(posedge sys_clk);
    cpu_irq_pending <= 1'b1;
    @(posedge sys_clk);
    cpu_irq_pending <= 1'b0;
    @(negedge sys_clk);
    chk("cpu_clk_en", 32'h1, {31'h0, cpu_clk_en});
    $display("t_wait done");
  endtask : t_wait
  task automatic t_sleep;
    wr_reg(lpms_pkg::REG_IRQ_EN, 32'h1);
    for (int i = 0; i < 4; i++) begin
      slow <= (i == 2);
      wr_reg(lpms_pkg::REG_IRQ_CLR, 32'h7);
      wr_reg(lpms_pkg::REG_CTRL, 32'h1);
      repeat (2) @(negedge sys_clk);
      chk("op_mode", 32'h1, {30'h0, op_mode});
      chk("xtal_en", 32'h0, {31'h0, xtal_en});
      chk("hs_clk_run", 32'h0, {31'h0, hs_clk_run});
      chk("irq", 32'h0, {31'h0, irq});
      @(posedge sys_clk);
      wake_req[i] <= 1'b1;
      wait_on();
      chk("irq", 32'h1, {31'h0, irq});
      @(posedge sys_clk);
      wake_req <= 4'h0;
    end
    slow <= 1'b0;
    wr_reg(lpms_pkg::REG_IRQ_EN, 32'h0);
    @(negedge sys_clk);
    chk("irq", 32'h0, {31'h0, irq});
    wr_reg(lpms_pkg::REG_IRQ_CLR, 32'h7);
    rd_reg(lpms_pkg::REG_IRQ_ST, rdv);
    chk("irq_st", 32'h0, rdv);
    $display("t_sleep done");
  endtask : t_sleep
  task automatic t_deep;
    @(posedge sys_clk);
    pad_oe_in <= 17'h1ffff;
    wr_reg(lpms_pkg::REG_RETAIN, 32'h5a5a_a5a5);
    wr_reg(lpms_pkg::REG_CTRL, 32'h6);
    repeat (3) @(negedge sys_clk);
    chk("op_mode", 32'h2, {30'h0, op_mode});
    chk("rtc_power_en", 32'h1, {31'h0, rtc_power_en});
    chk("pad_oe_out", 32'h0, {15'h0, pad_oe_out});
    chk("deep_wake_out", 32'h1, {31'h0, deep_sleep_wake_output});
    @(posedge sys_clk);
    wake_req <= 4'h8;
    repeat (5) @(negedge sys_clk);
    chk("deep_wake_out", 32'h0, {31'h0, deep_sleep_wake_output});
    wait_on();
    @(posedge sys_clk);
    wake_req <= 4'h0;
    rd_reg(lpms_pkg::REG_RETAIN, rdv);
    chk("retain", 32'h5a5a_a5a5, rdv);
    chk("pad_oe_out", 32'h1ffff, {15'h0, pad_oe_out});
    $display("t_deep done");
  endtask : t_deep
  task automatic t_off;
    @(posedge sys_clk);
    pwr_on <= 1'b0;
    repeat (8) @(negedge sys_clk);
    chk("rtc_power_en", 32'h0, {31'h0, rtc_power_en});
    chk("core_power_en", 32'h0, {31'h0, core_power_en});
    @(posedge sys_clk);
    pwr_on <= 1'b1;
    wait_on();
    rd_reg(lpms_pkg::REG_RETAIN, rdv);
    chk("retain", 32'h0, rdv);
    $display("t_off done");
  endtask : t_off
  task automatic end_of_test;
    $display("compares %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : end_of_test
  // main sequence
  initial begin
    repeat (4) @(posedge sys_clk);
    rst_n <= 1'b1;
    wait_on();
    t_regs();
    t_clk();
    t_wait();
    t_sleep();
    t_deep();
    t_off();
    end_of_test();
  end
  // watchdog
  initial begin
    #200000;
    error_cnt++;
    end_of_test();
  end
endmodule : tb_top
`default_nettype wire
